// ---- hdl/imucd_decoder.sv ----
// streaming-mode command decoder of an inertial measurement unit
// assumes a byte receiver and the datagram transmitter on ref_clk;
// external_sample_trigger arrives asynchronously from a pin
`timescale 1ns/10ps
module imucd_decoder #(
    parameter int FIFO_DEPTH = imucd_pkg::RX_FIFO_DEPTH,
    parameter int DGRAM_CYCLES = imucd_pkg::DGRAM_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] unit_address,
    input wire logic slot_tick,
    input wire logic trigger_mode,
    input wire logic external_sample_trigger,
    input wire logic tx_busy,
    input wire logic tx_done,
    input wire logic session_end,
    output logic dgram_start,
    output logic [2:0] dgram_kind,
    output logic clear_errors,
    output logic unit_reset,
    output logic session_enter,
    output logic listing_start,
    output logic streaming,
    output logic muted
);
    localparam int DW = $clog2(DGRAM_CYCLES + 1);
    localparam logic [DW-1:0] DELAY_LAST = DW'(DGRAM_CYCLES - 1);
    localparam logic [4:0] LEN_WORD = 5'(imucd_pkg::SESS_WORD_LEN);
    localparam logic [4:0] LEN_SAT = 5'h1f;

    typedef enum logic [2:0] {
        IMUCD_STREAM,
        IMUCD_WAIT_IDLE,
        IMUCD_ADDR_DELAY,
        IMUCD_SESSION,
        IMUCD_MUTED
    } imucd_state_type;

    imucd_state_type state_reg;

    imucd_stream_if #(.WIDTH(imucd_pkg::CHAR_WIDTH)) rx_in ();
    imucd_stream_if #(.WIDTH(imucd_pkg::CHAR_WIDTH)) rx_out ();

    assign rx_in.valid = rx_valid;
    assign rx_in.data = rx_data;
    assign rx_ready = rx_in.ready;

    imucd_fifo #(
        .WIDTH(imucd_pkg::CHAR_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .wr(rx_in),
        .rd(rx_out)
    );

    logic trig_sync;
    logic trig_prev_reg;

    imucd_sync2 u_trig_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .d(external_sample_trigger),
        .q(trig_sync)
    );

    // characters are held back while a mode change is waiting
    logic take_en;
    logic char_take;
    logic [7:0] ch;
    assign take_en = (state_reg != IMUCD_WAIT_IDLE) && (state_reg != IMUCD_ADDR_DELAY);
    assign rx_out.ready = take_en;
    assign char_take = rx_out.valid && take_en;
    assign ch = rx_out.data;

    // characters in the session and muted states are dropped unread
    logic decode_char;
    logic is_cr;
    logic is_digit;
    logic [7:0] word_char;
    assign decode_char = char_take && (state_reg == IMUCD_STREAM);
    assign is_cr = ch == imucd_pkg::CHAR_CR;
    assign is_digit = (ch >= imucd_pkg::CHAR_DIGIT0) && (ch <= imucd_pkg::CHAR_DIGIT9);

    // parser state
    logic [4:0] len_reg;
    logic [7:0] first_reg;
    logic word_ok_reg;
    logic sp_seen_reg;
    logic have_digit_reg;
    logic bad_reg;
    logic [8:0] addr_reg;
    logic [11:0] addr_acc;

    always_comb begin
        if (len_reg < LEN_WORD) begin
            word_char = imucd_pkg::SESS_WORD[8 * (imucd_pkg::SESS_WORD_LEN - 1 -
                        int'(len_reg)) +: 8];
        end else begin
            word_char = 8'h00;
        end
    end

    assign addr_acc = 12'(addr_reg) * imucd_pkg::ADDR_RADIX +
                      12'(ch - imucd_pkg::CHAR_DIGIT0);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            len_reg <= 5'h00;
            first_reg <= 8'h00;
            word_ok_reg <= 1'b1;
            sp_seen_reg <= 1'b0;
            have_digit_reg <= 1'b0;
            bad_reg <= 1'b0;
            addr_reg <= 9'h000;
        end else if (ce && decode_char) begin
            if (is_cr) begin
                // every line is consumed at carriage return, matched or not
                len_reg <= 5'h00;
                word_ok_reg <= 1'b1;
                sp_seen_reg <= 1'b0;
                have_digit_reg <= 1'b0;
                bad_reg <= 1'b0;
                addr_reg <= 9'h000;
            end else begin
                if (len_reg != LEN_SAT) begin
                    len_reg <= len_reg + 5'h01;
                end
                if (len_reg == 5'h00) begin
                    first_reg <= ch;
                end
                if (!sp_seen_reg) begin
                    if (len_reg < LEN_WORD) begin
                        // case matters: only the upper-case word matches
                        word_ok_reg <= word_ok_reg && (ch == word_char);
                    end else if (len_reg == LEN_WORD && ch == imucd_pkg::CHAR_SP) begin
                        sp_seen_reg <= word_ok_reg;
                    end else begin
                        word_ok_reg <= 1'b0;
                    end
                end else if (is_digit) begin
                    have_digit_reg <= 1'b1;
                    // saturate so any large address stays out of range
                    if (addr_acc > 12'(imucd_pkg::ADDR_MAX)) begin
                        addr_reg <= imucd_pkg::ADDR_SAT;
                    end else begin
                        addr_reg <= addr_acc[8:0];
                    end
                end else begin
                    bad_reg <= 1'b1;
                end
            end
        end
    end

    // command recognition at carriage return
    logic exec;
    logic single;
    logic cmd_reset;
    logic cmd_unaddr;
    logic cmd_addr;
    logic addr_match;
    logic [imucd_pkg::PEND_NUM-1:0] req_set;
    assign exec = decode_char && is_cr;
    assign single = len_reg == 5'h01;
    assign cmd_reset = exec && single && first_reg == imucd_pkg::CHAR_RESET;
    assign cmd_unaddr = exec && word_ok_reg && !sp_seen_reg && len_reg == LEN_WORD;
    assign cmd_addr = exec && sp_seen_reg && have_digit_reg && !bad_reg &&
                      addr_reg <= imucd_pkg::ADDR_MAX;
    assign addr_match = addr_reg[7:0] == unit_address;

    always_comb begin
        req_set = '0;
        if (exec && single) begin
            req_set[imucd_pkg::PEND_PART] = first_reg == imucd_pkg::CHAR_PART;
            req_set[imucd_pkg::PEND_SERIAL] = first_reg == imucd_pkg::CHAR_SERIAL;
            req_set[imucd_pkg::PEND_CONFIG] = first_reg == imucd_pkg::CHAR_CONFIG;
            req_set[imucd_pkg::PEND_BIAS] = first_reg == imucd_pkg::CHAR_BIAS;
            req_set[imucd_pkg::PEND_EXTERR] = first_reg == imucd_pkg::CHAR_EXTERR;
        end
    end

    // datagram slot scheduling
    logic trig_rise;
    logic slot;
    logic slot_free;
    logic [imucd_pkg::PEND_NUM-1:0] pend_reg;
    logic [imucd_pkg::PEND_NUM-1:0] pend_clr;
    logic [2:0] special_kind;
    logic ext_in_flight_reg;

    assign trig_rise = trig_sync && !trig_prev_reg;
    // in trigger mode a pulse opens the slot instead of the sample clock
    assign slot = trigger_mode ? trig_rise : slot_tick;
    // a slot that meets a datagram still on the line is dropped
    assign slot_free = slot && !tx_busy && (state_reg == IMUCD_STREAM);

    always_comb begin
        pend_clr = '0;
        special_kind = imucd_pkg::KIND_NORMAL;
        if (pend_reg[imucd_pkg::PEND_PART]) begin
            pend_clr[imucd_pkg::PEND_PART] = 1'b1;
            special_kind = imucd_pkg::KIND_PART;
        end else if (pend_reg[imucd_pkg::PEND_SERIAL]) begin
            pend_clr[imucd_pkg::PEND_SERIAL] = 1'b1;
            special_kind = imucd_pkg::KIND_SERIAL;
        end else if (pend_reg[imucd_pkg::PEND_CONFIG]) begin
            pend_clr[imucd_pkg::PEND_CONFIG] = 1'b1;
            special_kind = imucd_pkg::KIND_CONFIG;
        end else if (pend_reg[imucd_pkg::PEND_BIAS]) begin
            pend_clr[imucd_pkg::PEND_BIAS] = 1'b1;
            special_kind = imucd_pkg::KIND_BIAS;
        end else if (pend_reg[imucd_pkg::PEND_EXTERR]) begin
            pend_clr[imucd_pkg::PEND_EXTERR] = 1'b1;
            special_kind = imucd_pkg::KIND_EXTERR;
        end
        if (!slot_free) begin
            pend_clr = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            trig_prev_reg <= 1'b0;
        end else if (ce) begin
            trig_prev_reg <= trig_sync;
        end
    end

    // a new request wins over the clear of the same bit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend_reg <= '0;
        end else if (ce) begin
            pend_reg <= (pend_reg & ~pend_clr) | req_set;
        end
    end

    // one datagram per free slot, special ones first
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dgram_start <= 1'b0;
            dgram_kind <= imucd_pkg::KIND_NORMAL;
        end else if (ce) begin
            dgram_start <= slot_free;
            if (slot_free) begin
                dgram_kind <= special_kind;
            end
        end
    end

    // error registers are cleared once the extended error datagram ends
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ext_in_flight_reg <= 1'b0;
            clear_errors <= 1'b0;
        end else if (ce) begin
            clear_errors <= tx_done && ext_in_flight_reg;
            if (slot_free && special_kind == imucd_pkg::KIND_EXTERR) begin
                ext_in_flight_reg <= 1'b1;
            end else if (tx_done) begin
                ext_in_flight_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            unit_reset <= 1'b0;
        end else if (ce) begin
            unit_reset <= cmd_reset;
        end
    end

    // mode control
    logic addressed_reg;
    logic [DW-1:0] delay_reg;
    logic enter_now;

    assign enter_now = (state_reg == IMUCD_WAIT_IDLE && !tx_busy && !addressed_reg) ||
                       (state_reg == IMUCD_ADDR_DELAY && delay_reg == DELAY_LAST);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= IMUCD_STREAM;
            addressed_reg <= 1'b0;
            delay_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                IMUCD_STREAM: begin
                    if (cmd_unaddr) begin
                        addressed_reg <= 1'b0;
                        state_reg <= IMUCD_WAIT_IDLE;
                    end else if (cmd_addr && addr_match) begin
                        addressed_reg <= 1'b1;
                        state_reg <= IMUCD_WAIT_IDLE;
                    end else if (cmd_addr) begin
                        state_reg <= IMUCD_MUTED;
                    end
                end
                IMUCD_WAIT_IDLE: begin
                    // the datagram on the line is completed first
                    if (!tx_busy) begin
                        delay_reg <= '0;
                        state_reg <= addressed_reg ? IMUCD_ADDR_DELAY : IMUCD_SESSION;
                    end
                end
                IMUCD_ADDR_DELAY: begin
                    // one datagram time lets other units finish
                    delay_reg <= delay_reg + 1'b1;
                    if (delay_reg == DELAY_LAST) begin
                        state_reg <= IMUCD_SESSION;
                    end
                end
                IMUCD_SESSION: begin
                    if (session_end) begin
                        state_reg <= IMUCD_STREAM;
                    end
                end
                IMUCD_MUTED: begin
                    // resume silently, the exit is not answered
                    if (session_end) begin
                        state_reg <= IMUCD_STREAM;
                    end
                end
                default: begin
                    state_reg <= IMUCD_STREAM;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            session_enter <= 1'b0;
            listing_start <= 1'b0;
        end else if (ce) begin
            session_enter <= enter_now;
            listing_start <= enter_now;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            streaming <= 1'b1;
            muted <= 1'b0;
        end else if (ce) begin
            streaming <= (state_reg == IMUCD_STREAM) && !cmd_unaddr && !cmd_addr;
            muted <= (state_reg == IMUCD_MUTED) ? !session_end :
                     (state_reg == IMUCD_STREAM && cmd_addr && !addr_match);
        end
    end
endmodule

// ---- hdl/imucd_fifo.sv ----
// receive character fifo with registered read data
// assumes writer and reader on ref_clk; capacity is DEPTH plus the output word
`timescale 1ns/10ps
module imucd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    imucd_stream_if.snk wr,
    imucd_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic [AW:0] cnt_next;
    logic in_ready_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic push;
    logic pop;

    assign wr.ready = in_ready_reg;
    assign rd.valid = out_valid_reg;
    assign rd.data = out_data_reg;
    assign push = wr.valid && in_ready_reg;
    // move a word to the output register when it is empty or being taken
    assign pop = (cnt_reg != '0) && (!out_valid_reg || rd.ready);
    assign cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);

    always_ff @(posedge ref_clk) begin
        if (ce && push) begin
            mem[wptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            in_ready_reg <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            cnt_reg <= cnt_next;
            in_ready_reg <= cnt_next < DEPTH_CNT;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (ce) begin
            if (pop) begin
                out_valid_reg <= 1'b1;
                out_data_reg <= mem[rptr_reg];
            end else if (rd.ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end
endmodule

// ---- hdl/imucd_sync2.sv ----
// two-stage synchroniser for a level arriving from a pin
// assumes the input may change at any time relative to ref_clk
`timescale 1ns/10ps
module imucd_sync2 (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_reg;

    // first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ---- inc/imucd_pkg.sv ----
// constants shared by the streaming-mode command decoder
// assumes 8-bit received characters and one device clock
package imucd_pkg;

    // character codes of the command set
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_SP = 8'h20;
    localparam logic [7:0] CHAR_PART = 8'h4e;
    localparam logic [7:0] CHAR_SERIAL = 8'h49;
    localparam logic [7:0] CHAR_CONFIG = 8'h43;
    localparam logic [7:0] CHAR_BIAS = 8'h54;
    localparam logic [7:0] CHAR_EXTERR = 8'h45;
    localparam logic [7:0] CHAR_RESET = 8'h52;
    localparam logic [7:0] CHAR_DIGIT0 = 8'h30;
    localparam logic [7:0] CHAR_DIGIT9 = 8'h39;

    // maintenance session entry word, first character in the top byte
    localparam int SESS_WORD_LEN = 11;
    localparam logic [87:0] SESS_WORD = 88'h5345_5256_4943_454d_4f44_45;

    // unit address range and saturation value of the address accumulator
    localparam logic [8:0] ADDR_MAX = 9'h0ff;
    localparam logic [8:0] ADDR_SAT = 9'h100;
    localparam logic [11:0] ADDR_RADIX = 12'h00a;

    // datagram kinds handed to the transmitter
    localparam logic [2:0] KIND_NORMAL = 3'h0;
    localparam logic [2:0] KIND_PART = 3'h1;
    localparam logic [2:0] KIND_SERIAL = 3'h2;
    localparam logic [2:0] KIND_CONFIG = 3'h3;
    localparam logic [2:0] KIND_BIAS = 3'h4;
    localparam logic [2:0] KIND_EXTERR = 3'h5;

    // pending request bit positions
    localparam int PEND_PART = 0;
    localparam int PEND_SERIAL = 1;
    localparam int PEND_CONFIG = 2;
    localparam int PEND_BIAS = 3;
    localparam int PEND_EXTERR = 4;
    localparam int PEND_NUM = 5;

    // receive path
    localparam int CHAR_WIDTH = 8;
    localparam int RX_FIFO_DEPTH = 16;

    // one datagram transmission time, in device clock cycles
    localparam int DGRAM_CYCLES = 1000;

endpackage

// ---- inc/imucd_stream_if.sv ----
// valid/ready character stream between the decoder's own modules
// assumes source and sink share one clock
`timescale 1ns/10ps
interface imucd_stream_if #(
    parameter int WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- test/imucd_decoder_asserts.sv ----
// port assertions for the streaming-mode command decoder
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/10ps
module imucd_decoder_asserts (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic slot_tick,
    input wire logic trigger_mode,
    input wire logic tx_busy,
    input wire logic tx_done,
    input wire logic session_end,
    input wire logic dgram_start,
    input wire logic clear_errors,
    input wire logic unit_reset,
    input wire logic session_enter,
    input wire logic listing_start,
    input wire logic streaming,
    input wire logic muted
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_free_slot;
        slot_tick && !tx_busy && !trigger_mode && streaming && !muted;
    endsequence
    sequence s_mute_end;
        muted && session_end;
    endsequence
    a_slot_gives_start: assert property (s_free_slot |=> dgram_start)
        else $error("free slot gave no datagram");
    a_busy_blocks: assert property (dgram_start |-> !$past(tx_busy))
        else $error("datagram started over a busy line");
    a_timed_start: assert property (dgram_start && !trigger_mode |-> $past(slot_tick))
        else $error("datagram started without a slot");
    a_clear_follows: assert property (clear_errors |-> $past(tx_done))
        else $error("error clear without finished datagram");
    a_reset_pulse: assert property (unit_reset |=> !unit_reset)
        else $error("unit reset longer than one cycle");
    a_enter_idle: assert property (session_enter |-> !tx_busy && !$past(tx_busy))
        else $error("session entered during a datagram");
    a_enter_leaves: assert property (session_enter |=> !streaming)
        else $error("still streaming after session entry");
    a_listing_with_enter: assert property (listing_start == session_enter)
        else $error("listing not paired with session entry");
    a_muted_quiet: assert property (muted |-> !dgram_start)
        else $error("datagram started while muted");
    a_mute_resume: assert property (s_mute_end |=> !muted ##1 streaming)
        else $error("no return to streaming after session end");
endmodule
bind imucd_decoder imucd_decoder_asserts chk_u (.ref_clk(ref_clk), .rstn(rstn),
    .slot_tick(slot_tick), .trigger_mode(trigger_mode), .tx_busy(tx_busy),
    .tx_done(tx_done), .session_end(session_end), .dgram_start(dgram_start),
    .clear_errors(clear_errors), .unit_reset(unit_reset), .session_enter(session_enter),
    .listing_start(listing_start), .streaming(streaming), .muted(muted));

// ---- test/imucd_decoder_tb_top.sv ----
// self-checking bench for the streaming-mode command decoder
// assumes the host model drives the character stream and transmitter status
`timescale 1ns/10ps
module imucd_decoder_tb_top;
    localparam int DG = 8;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic slot_tick = 1'b0;
    logic trigger_mode = 1'b0;
    logic ext_trig = 1'b0;
    logic session_end = 1'b0;
    logic [7:0] unit_address = 8'h05;
    logic [15:0] tx_len = 16'h0003;
    logic [7:0] rx_data;
    logic [2:0] dgram_kind;
    logic rx_valid, rx_ready, tx_busy, tx_done, dgram_start, clear_errors;
    logic unit_reset, session_enter, listing_start, streaming, muted;
    string sw;
    int bad_count = 0;
    int n_compared = 0;
    always #12.5 ref_clk = ~ref_clk;
    imucd_decoder #(.DGRAM_CYCLES(DG)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .unit_address(unit_address), .slot_tick(slot_tick), .trigger_mode(trigger_mode),
        .external_sample_trigger(ext_trig), .tx_busy(tx_busy), .tx_done(tx_done),
        .session_end(session_end), .dgram_start(dgram_start), .dgram_kind(dgram_kind),
        .clear_errors(clear_errors), .unit_reset(unit_reset), .session_enter(session_enter),
        .listing_start(listing_start), .streaming(streaming), .muted(muted));
    imucd_host_model host_u (.ref_clk(ref_clk), .rx_ready(rx_ready),
        .dgram_start(dgram_start), .tx_len(tx_len), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_busy(tx_busy), .tx_done(tx_done));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic cmd(input string s);
        host_u.send_line(s);
        cycles(4);
    endtask
    task automatic wait_idle;
        cycles(1);
        for (int i = 0; i < 300 && tx_busy; i++) @(negedge ref_clk);
        cycles(2);
    endtask
    task automatic tick;
        @(negedge ref_clk);
        slot_tick = 1'b1;
        @(negedge ref_clk);
        slot_tick = 1'b0;
    endtask
    task automatic slot(input logic exp_start, input logic [2:0] exp_kind);
        tick();
        check(dgram_start, exp_start);
        if (exp_start) check(dgram_kind, exp_kind);
        wait_idle();
    endtask
    task automatic end_session;
        @(negedge ref_clk);
        session_end = 1'b1;
        @(negedge ref_clk);
        session_end = 1'b0;
        cycles(1);
        check(streaming, 1'b1);
    endtask
    task automatic t_requests;
        string c[5] = '{"N", "I", "C", "T", "E"};
        logic [2:0] k[5] = '{imucd_pkg::KIND_PART, imucd_pkg::KIND_SERIAL,
            imucd_pkg::KIND_CONFIG, imucd_pkg::KIND_BIAS, imucd_pkg::KIND_EXTERR};
        for (int i = 0; i < 5; i++) begin
            cmd(c[i]);
            tick();
            check(dgram_kind, k[i]);
            for (int j = 0; j < 20 && !clear_errors; j++) @(negedge ref_clk);
            check(clear_errors, i == 4);
            wait_idle();
            slot(1'b1, imucd_pkg::KIND_NORMAL);
        end
    endtask
    task automatic t_suppress;
        tx_len = 16'h0028;
        cmd("T");
        tick();
        check(dgram_start, 1'b1);
        check(dgram_kind, imucd_pkg::KIND_BIAS);
        tick();
        check(dgram_start, 1'b0);
        wait_idle();
        tx_len = 16'h0003;
    endtask
    task automatic t_bad;
        cmd("n");
        cmd("NN");
        cmd("X");
        cmd({sw, " 256"});
        cmd({sw, "1"});
        check(muted, 1'b0);
        check(streaming, 1'b1);
        slot(1'b1, imucd_pkg::KIND_NORMAL);
    endtask
    task automatic t_trigger;
        trigger_mode = 1'b1;
        cmd("I");
        slot(1'b0, imucd_pkg::KIND_NORMAL);
        ext_trig = 1'b1;
        for (int i = 0; i < 10 && !dgram_start; i++) @(negedge ref_clk);
        check(dgram_start, 1'b1);
        check(dgram_kind, imucd_pkg::KIND_SERIAL);
        ext_trig = 1'b0;
        wait_idle();
        trigger_mode = 1'b0;
    endtask
    task automatic t_muted;
        cmd({sw, " 7"});
        check(muted, 1'b1);
        slot(1'b0, imucd_pkg::KIND_NORMAL);
        cmd("N");
        end_session();
        slot(1'b1, imucd_pkg::KIND_NORMAL);
    endtask
    task automatic t_addressed;
        int n;
        host_u.send_line({sw, " 005"});
        for (n = 0; n < 100 && !session_enter; n++) @(negedge ref_clk);
        check(n >= DG && n <= DG + 6, 1'b1);
        check(listing_start, 1'b1);
        cycles(1);
        check(streaming, 1'b0);
        end_session();
    endtask
    task automatic t_unaddressed;
        int n;
        tx_len = 16'h0064;
        tick();
        fork
            begin
                host_u.send_line(sw);
                host_u.send_line("ZZZZZZZZZZZZZZZZZZZZ");
            end
            begin
                for (n = 0; n < 80 && rx_ready; n++) @(negedge ref_clk);
                check(rx_ready, 1'b0);
                for (n = 0; n < 200 && !session_enter; n++) @(negedge ref_clk);
                check(session_enter, 1'b1);
                check(tx_busy, 1'b0);
                check(listing_start, 1'b1);
            end
        join
        end_session();
        tx_len = 16'h0003;
    endtask
    task automatic t_reset;
        int n;
        host_u.send_line("R");
        for (n = 0; n < 40 && !unit_reset; n++) @(negedge ref_clk);
        check(unit_reset, 1'b1);
    endtask
    initial begin
        for (int i = 0; i < imucd_pkg::SESS_WORD_LEN; i++) begin
            sw = {sw, string'(imucd_pkg::SESS_WORD[87 - 8 * i -: 8])};
        end
        repeat (5) @(negedge ref_clk);
        check(streaming, 1'b1);
        check(rx_ready, 1'b0);
        rstn = 1'b1;
        cycles(3);
        t_requests();
        t_suppress();
        t_bad();
        t_trigger();
        t_muted();
        t_addressed();
        t_unaddressed();
        t_reset();
        print_verdict();
    end
    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end
endmodule

// ---- test/imucd_host_model.sv ----
// host line and datagram transmitter standing opposite the decoder
// assumes the decoder samples on the rising edge of ref_clk
`timescale 1ns/10ps
module imucd_host_model (
    input wire logic ref_clk,
    input wire logic rx_ready,
    input wire logic dgram_start,
    input wire logic [15:0] tx_len,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic tx_busy,
    output logic tx_done
);
    int tx_cnt = 0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_busy = 1'b0;
        tx_done = 1'b0;
    end
    // one character per accepted handshake, line closed by carriage return
    task automatic send_line(input string s);
        for (int i = 0; i <= s.len(); i++) begin
            @(negedge ref_clk);
            rx_valid = 1'b1;
            rx_data = (i == s.len()) ? imucd_pkg::CHAR_CR : s[i];
            while (!rx_ready) @(negedge ref_clk);
            @(posedge ref_clk);
        end
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
    // a started datagram holds the line for tx_len cycles
    always @(negedge ref_clk) begin
        tx_done <= 1'b0;
        if (tx_cnt > 0) begin
            tx_cnt <= tx_cnt - 1;
            if (tx_cnt == 1) begin
                tx_busy <= 1'b0;
                tx_done <= 1'b1;
            end
        end else if (dgram_start) begin
            tx_busy <= 1'b1;
            tx_cnt <= int'(tx_len);
        end
    end
endmodule
